// ===== hw/rpf_cfg.svh
// Offsets, field positions, reset values and counts for the receive
// packet filter. Assumes the includer uses them at the widths given.
`ifndef RPF_CFG_SVH
`define RPF_CFG_SVH

// Register offsets on the register port
`define RPF_ADR_THR 6'h03
`define RPF_ADR_SYNC_HI 6'h04
`define RPF_ADR_SYNC_LO 6'h05
`define RPF_ADR_FRAME 6'h06
`define RPF_ADR_CTRL1 6'h07
`define RPF_ADR_CTRL0 6'h08
`define RPF_ADR_DEV 6'h09

// Reset values
`define RPF_RST_THR 8'h07
`define RPF_RST_SYNC_HI 8'hD3
`define RPF_RST_SYNC_LO 8'h91
`define RPF_RST_FRAME 8'hFF
`define RPF_RST_CTRL1 8'h04
`define RPF_RST_CTRL0 8'h45
`define RPF_RST_DEV 8'h00

// Writable bits; unused bits read as zero
`define RPF_WMASK_CTRL1 8'hEF
`define RPF_WMASK_CTRL0 8'h77

// Field positions
`define RPF_C1_FLUSH_BIT 3
`define RPF_C1_TRAIL_BIT 2
`define RPF_C0_CRCEN_BIT 2
`define RPF_C0_FMT_HI 5
`define RPF_C0_FMT_LO 4

// Broadcast addresses
`define RPF_BCAST_ZERO 8'h00
`define RPF_BCAST_ONES 8'hFF

// Threshold arithmetic: receive 4*(n+1), transmit 61-4n
`define RPF_THR_STEP 4
`define RPF_TX_THR_BASE 61

// Receive queue address width (64 bytes)
`define RPF_FIFO_AW 6

`endif

// ===== hw/rpf_pkg.sv
// Types shared by the receive packet filter modules.
// Assumes nothing beyond a SystemVerilog compiler.
package rpf_pkg;

   // Packet sequencer states
   typedef enum logic [6:0] {
      RPF_IDLE = 7'b000_0001,
      RPF_LEN = 7'b000_0010,
      RPF_ADDR = 7'b000_0100,
      RPF_DATA = 7'b000_1000,
      RPF_CRC = 7'b001_0000,
      RPF_ST1 = 7'b010_0000,
      RPF_ST2 = 7'b100_0000
   } rpf_state_t;

   // Length mode field encodings
   typedef enum logic [1:0] {
      RPF_LEN_FIXED = 2'b00,
      RPF_LEN_VAR = 2'b01,
      RPF_LEN_INF = 2'b10,
      RPF_LEN_RSV = 2'b11
   } rpf_len_mode_t;

   // Address filter select encodings
   typedef enum logic [1:0] {
      RPF_AF_OFF = 2'b00,
      RPF_AF_DEV = 2'b01,
      RPF_AF_DEV_ZERO = 2'b10,
      RPF_AF_DEV_BOTH = 2'b11
   } rpf_addr_filter_t;

   // Received byte from the demodulator
   typedef struct packed {
      logic vld;
      logic [7:0] data;
   } rpf_rxb_t;

   // Check result from the CRC engine
   typedef struct packed {
      logic vld;
      logic ok;
   } rpf_crc_t;

   // Link quality figures for the status trailer
   typedef struct packed {
      logic [7:0] rssi;
      logic [6:0] lqi;
   } rpf_qual_t;

   // Register port request
   typedef struct packed {
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } rpf_reg_req_t;

endpackage

// ===== hw/rpf_gate.sv
// Address filter decision and queue threshold comparison.
// Purely combinational; fed from registered state of the top module plus the live transmit level and received byte.
`timescale 1ns/10ps
`include "rpf_cfg.svh"
module rpf_gate #(
   parameter int LW = `RPF_FIFO_AW + 1
) (
   // Settings
   input wire logic [3:0] thr_sel,
   input wire logic [1:0] filter,
   input wire logic [7:0] dev_addr,
   // Observed values
   input wire logic [LW-1:0] rx_level,
   input wire logic [LW-1:0] tx_level,
   input wire logic [7:0] rx_addr,
   // Decisions
   output logic rx_thr,
   output logic tx_thr,
   output logic addr_ok
);

   // Receive threshold, 4 bytes per step from 4
   function automatic logic [LW-1:0] rx_limit(input logic [3:0] n);
      rx_limit = LW'(`RPF_THR_STEP * (int'(n) + 1));
   endfunction

   // Transmit threshold, falling 4 bytes per step from 61
   function automatic logic [LW-1:0] tx_limit(input logic [3:0] n);
      tx_limit = LW'(`RPF_TX_THR_BASE - `RPF_THR_STEP * int'(n));
   endfunction

   // Exceeded once the level reaches the limit
   assign rx_thr = rx_level >= rx_limit(thr_sel);
   assign tx_thr = tx_level >= tx_limit(thr_sel);

   // Address acceptance per filter setting
   always_comb begin
      unique case (rpf_pkg::rpf_addr_filter_t'(filter))
         rpf_pkg::RPF_AF_OFF: addr_ok = 1'b1;
         rpf_pkg::RPF_AF_DEV: addr_ok = rx_addr == dev_addr;
         rpf_pkg::RPF_AF_DEV_ZERO: begin
            addr_ok = rx_addr == dev_addr ||
                      rx_addr == `RPF_BCAST_ZERO;
         end
         rpf_pkg::RPF_AF_DEV_BOTH: begin
            addr_ok = rx_addr == dev_addr ||
                      rx_addr == `RPF_BCAST_ZERO ||
                      rx_addr == `RPF_BCAST_ONES;
         end
      endcase
   end

endmodule

// ===== hw/rpf_top.sv
// Receive packet filter: settings registers, packet sequencer, address
// filter, status trailer and the receive byte queue.
// Assumes demodulator, CRC engine and register port share clk_sys and
// that received bytes arrive at least two cycles apart.
`timescale 1ns/10ps
`include "rpf_cfg.svh"
module rpf_top #(
   parameter int FIFO_AW = `RPF_FIFO_AW
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // Register port
   input wire rpf_pkg::rpf_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // Receive stream from demodulator and CRC engine
   input wire logic sync_det,
   input wire rpf_pkg::rpf_rxb_t rxb,
   input wire rpf_pkg::rpf_crc_t crc_res,
   input wire rpf_pkg::rpf_qual_t rqual,
   input wire logic rx_abort,
   // Receive queue read side
   input wire logic fifo_rd,
   input wire logic fifo_flush,
   output logic [7:0] fifo_rdata,
   output logic fifo_empty,
   output logic [FIFO_AW:0] rx_count,
   output logic rx_ovf,
   // Thresholds
   input wire logic [FIFO_AW:0] tx_count,
   output logic rx_thr,
   output logic tx_thr,
   // Settings for the modem and transmit path
   output logic [15:0] sync_word,
   output logic crc_enable,
   output logic [1:0] pkt_format
);

   localparam int DEPTH = 1 << FIFO_AW;
   localparam logic [FIFO_AW:0] DEPTH_C = (FIFO_AW + 1)'(DEPTH);

   typedef struct packed {
      logic [7:0] thr;
      logic [7:0] sync_hi;
      logic [7:0] sync_lo;
      logic [7:0] frame;
      logic [7:0] ctrl1;
      logic [7:0] ctrl0;
      logic [7:0] dev_addr;
      rpf_pkg::rpf_state_t st;
      logic [7:0] remain;
      logic [7:0] len_hold;
      logic [7:0] addr_hold;
      logic addr_pend;
      logic crc_ok_hold;
      logic [FIFO_AW-1:0] wptr;
      logic [FIFO_AW-1:0] rptr;
      logic [FIFO_AW:0] cnt;
      logic ovf;
      logic [7:0] reg_rd;
      logic [7:0] fifo_out;
   } rpf_core_t;

   localparam rpf_core_t RST_C = '{
      thr: `RPF_RST_THR,
      sync_hi: `RPF_RST_SYNC_HI,
      sync_lo: `RPF_RST_SYNC_LO,
      frame: `RPF_RST_FRAME,
      ctrl1: `RPF_RST_CTRL1,
      ctrl0: `RPF_RST_CTRL0,
      dev_addr: `RPF_RST_DEV,
      st: rpf_pkg::RPF_IDLE,
      default: '0
   };

   logic rst_meta_n, rst_q_n;
   rpf_core_t r, n;
   logic [7:0] mem [DEPTH];
   logic [7:0] wr_data;
   logic wr_en, push, pop, flush_now;
   logic addr_ok, is_var, trail_en, flush_en;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_q_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_q_n <= rst_meta_n;
      end
   end

   // Register read decode, unmapped offsets read zero
   function automatic logic [7:0] rd_mux(input rpf_core_t s,
                                         input logic [5:0] a);
      case (a)
         `RPF_ADR_THR: rd_mux = s.thr;
         `RPF_ADR_SYNC_HI: rd_mux = s.sync_hi;
         `RPF_ADR_SYNC_LO: rd_mux = s.sync_lo;
         `RPF_ADR_FRAME: rd_mux = s.frame;
         `RPF_ADR_CTRL1: rd_mux = s.ctrl1;
         `RPF_ADR_CTRL0: rd_mux = s.ctrl0;
         `RPF_ADR_DEV: rd_mux = s.dev_addr;
         default: rd_mux = 8'h00;
      endcase
   endfunction

   // Filter decision and thresholds
   rpf_gate #(
      .LW(FIFO_AW + 1)
   ) u_gate (
      .thr_sel(r.thr[3:0]),
      .filter(r.ctrl1[1:0]),
      .dev_addr(r.dev_addr),
      .rx_level(r.cnt),
      .tx_level(tx_count),
      .rx_addr(rxb.data),
      .rx_thr(rx_thr),
      .tx_thr(tx_thr),
      .addr_ok(addr_ok)
   );

   assign is_var = r.ctrl0[1:0] == rpf_pkg::RPF_LEN_VAR;
   assign trail_en = r.ctrl1[`RPF_C1_TRAIL_BIT];
   assign flush_en = r.ctrl1[`RPF_C1_FLUSH_BIT];

   // Next state: registers, sequencer and queue bookkeeping
   always_comb begin
      n = r;
      wr_en = 1'b0;
      wr_data = 8'h00;
      flush_now = fifo_flush;
      n.reg_rd = rd_mux(r, reg_req.addr);
      if (reg_req.wr) begin
         case (reg_req.addr)
            `RPF_ADR_THR: n.thr = reg_req.wdata;
            `RPF_ADR_SYNC_HI: n.sync_hi = reg_req.wdata;
            `RPF_ADR_SYNC_LO: n.sync_lo = reg_req.wdata;
            `RPF_ADR_FRAME: n.frame = reg_req.wdata;
            `RPF_ADR_CTRL1: n.ctrl1 = reg_req.wdata & `RPF_WMASK_CTRL1;
            `RPF_ADR_CTRL0: n.ctrl0 = reg_req.wdata & `RPF_WMASK_CTRL0;
            `RPF_ADR_DEV: n.dev_addr = reg_req.wdata;
            default: n.thr = r.thr;
         endcase
      end
      // Deferred address byte after a held length byte
      n.addr_pend = 1'b0;
      if (r.addr_pend) begin
         wr_en = 1'b1;
         wr_data = r.addr_hold;
      end
      unique case (r.st)
         rpf_pkg::RPF_IDLE: begin
            if (sync_det) begin
               unique case (rpf_pkg::rpf_len_mode_t'(r.ctrl0[1:0]))
                  rpf_pkg::RPF_LEN_VAR: n.st = rpf_pkg::RPF_LEN;
                  rpf_pkg::RPF_LEN_FIXED: begin
                     n.remain = r.frame;
                     n.st = r.ctrl1[1:0] != 2'b00 ? rpf_pkg::RPF_ADDR
                                                  : rpf_pkg::RPF_DATA;
                  end
                  rpf_pkg::RPF_LEN_INF: n.st = rpf_pkg::RPF_DATA;
                  rpf_pkg::RPF_LEN_RSV: n.st = rpf_pkg::RPF_IDLE;
               endcase
            end
         end
         rpf_pkg::RPF_LEN: begin
            if (rxb.vld) begin
               n.len_hold = rxb.data;
               n.remain = rxb.data;
               if (rxb.data == 8'h00 || rxb.data > r.frame) begin
                  n.st = rpf_pkg::RPF_IDLE;
               end else if (r.ctrl1[1:0] != 2'b00) begin
                  n.st = rpf_pkg::RPF_ADDR; // Hold length until address
               end else begin
                  wr_en = 1'b1;
                  wr_data = rxb.data;
                  n.st = rpf_pkg::RPF_DATA;
               end
            end
         end
         rpf_pkg::RPF_ADDR: begin
            if (rxb.vld) begin
               n.remain = r.remain - 8'h01;
               if (!addr_ok) begin
                  n.st = rpf_pkg::RPF_IDLE;
               end else begin
                  wr_en = 1'b1;
                  wr_data = is_var ? r.len_hold : rxb.data;
                  n.addr_pend = is_var;
                  n.addr_hold = rxb.data;
                  n.st = r.remain == 8'h01 ? rpf_pkg::RPF_CRC
                                           : rpf_pkg::RPF_DATA;
               end
            end
         end
         rpf_pkg::RPF_DATA: begin
            if (rxb.vld) begin
               wr_en = 1'b1;
               wr_data = rxb.data;
               if (r.ctrl0[1:0] != rpf_pkg::RPF_LEN_INF) begin
                  n.remain = r.remain - 8'h01;
                  if (r.remain == 8'h01) n.st = rpf_pkg::RPF_CRC;
               end
            end
         end
         rpf_pkg::RPF_CRC: begin
            // Without checking there is no verdict; flag reads as bad
            if (!r.ctrl0[`RPF_C0_CRCEN_BIT]) begin
               n.crc_ok_hold = 1'b0;
               n.st = trail_en ? rpf_pkg::RPF_ST1 : rpf_pkg::RPF_IDLE;
            end else if (crc_res.vld) begin
               n.crc_ok_hold = crc_res.ok;
               if (!crc_res.ok && flush_en) begin
                  flush_now = 1'b1;
                  n.st = rpf_pkg::RPF_IDLE;
               end else begin
                  n.st = trail_en ? rpf_pkg::RPF_ST1
                                  : rpf_pkg::RPF_IDLE;
               end
            end
         end
         rpf_pkg::RPF_ST1: begin
            wr_en = 1'b1;
            wr_data = rqual.rssi;
            n.st = rpf_pkg::RPF_ST2;
         end
         rpf_pkg::RPF_ST2: begin
            wr_en = 1'b1;
            wr_data = {r.crc_ok_hold, rqual.lqi};
            n.st = rpf_pkg::RPF_IDLE;
         end
      endcase
      // Carrier loss ends the packet where it stands
      if (rx_abort) n.st = rpf_pkg::RPF_IDLE;
      // Queue: a byte arriving while full with no pop in the same cycle is lost and flagged
      pop = fifo_rd && r.cnt != '0;
      push = wr_en && (r.cnt != DEPTH_C || pop);
      if (wr_en && !push) n.ovf = 1'b1;
      if (pop) begin
         n.fifo_out = mem[r.rptr];
         n.rptr = r.rptr + 1'b1;
      end
      if (push) n.wptr = r.wptr + 1'b1;
      n.cnt = r.cnt + (FIFO_AW + 1)'(push) - (FIFO_AW + 1)'(pop);
      if (flush_now) begin
         n.wptr = '0;
         n.rptr = '0;
         n.cnt = '0;
         n.ovf = 1'b0;
      end
   end

   // State register; enable low freezes everything
   always_ff @(posedge clk_sys or negedge rst_q_n) begin
      if (!rst_q_n) r <= RST_C;
      else if (ce) r <= n;
   end

   // Queue storage, no reset needed since count guards reads
   always_ff @(posedge clk_sys) begin
      if (ce && push) mem[r.wptr] <= wr_data;
   end

   // Outputs straight from state
   assign reg_rdata = r.reg_rd;
   assign fifo_rdata = r.fifo_out;
   assign fifo_empty = r.cnt == '0;
   assign rx_count = r.cnt;
   assign rx_ovf = r.ovf;
   assign sync_word = {r.sync_hi, r.sync_lo};
   assign crc_enable = r.ctrl0[`RPF_C0_CRCEN_BIT];
   assign pkt_format = r.ctrl0[`RPF_C0_FMT_HI:`RPF_C0_FMT_LO];

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_q_n);
   sync_reset_a: assert property (
      $rose(rst_q_n) |-> sync_word == {`RPF_RST_SYNC_HI, `RPF_RST_SYNC_LO}
   ) else $error("sync word reset value wrong");
   sync_low_wr_a: assert property (
      ce && reg_req.wr && reg_req.addr == `RPF_ADR_SYNC_LO
      |=> sync_word[7:0] == $past(reg_req.wdata)
   ) else $error("low sync byte not written");
   fixed_len_a: assert property (
      ce && r.st == rpf_pkg::RPF_IDLE && sync_det && !rx_abort &&
      r.ctrl0[1:0] == rpf_pkg::RPF_LEN_FIXED |=> r.remain == $past(r.frame)
   ) else $error("fixed length not loaded");
   len_limit_a: assert property (
      ce && r.st == rpf_pkg::RPF_LEN && rxb.vld && rxb.data > r.frame
      |-> !wr_en ##1 r.st == rpf_pkg::RPF_IDLE
   ) else $error("overlong packet not dropped");
   crc_flush_a: assert property (
      ce && r.st == rpf_pkg::RPF_CRC && crc_res.vld && !crc_res.ok &&
      flush_en && r.ctrl0[`RPF_C0_CRCEN_BIT] |=> rx_count == '0
   ) else $error("bad packet not flushed");
   // Carrier loss in the first trailer cycle legally cuts the second
   trailer_a: assert property (
      ce && r.st == rpf_pkg::RPF_ST1 && !rx_abort
      |-> wr_en && wr_data == rqual.rssi
      ##1 (!ce || (wr_en && wr_data[7] == r.crc_ok_hold))
   ) else $error("status trailer bytes wrong");
   addr_reject_a: assert property (
      ce && r.st == rpf_pkg::RPF_ADDR && rxb.vld && !addr_ok
      |-> !wr_en ##1 (r.st == rpf_pkg::RPF_IDLE && !r.addr_pend)
   ) else $error("rejected packet reached queue");
   addr_dev_a: assert property (
      ce && r.st == rpf_pkg::RPF_ADDR && rxb.vld &&
      r.ctrl1[1:0] == 2'b01 && rxb.data != r.dev_addr |-> !addr_ok
   ) else $error("foreign address accepted");
   bcast_ones_a: assert property (
      r.ctrl1[1:0] == 2'b11 && rxb.data == `RPF_BCAST_ONES |-> addr_ok
   ) else $error("broadcast FF refused");
   rx_thr_a: assert property (
      rx_thr == (int'(rx_count) >= `RPF_THR_STEP * (int'(r.thr[3:0]) + 1))
   ) else $error("receive threshold wrong");
   len_mode_a: assert property (
      $rose(rst_q_n) |-> r.ctrl0[1:0] == rpf_pkg::RPF_LEN_VAR
   ) else $error("length mode not variable at reset");

endmodule

// ===== sim/rpf_src.sv
// Model of the demodulator and CRC engine that feed the filter.
// Assumes the bench calls send() and that clk_sys runs free.
`timescale 1ns/10ps
module rpf_src (
   // Clock
   input wire logic clk_sys,
   // Stream towards the filter
   output logic sync_det,
   output rpf_pkg::rpf_rxb_t rxb,
   output rpf_pkg::rpf_crc_t crc_res,
   output rpf_pkg::rpf_qual_t rqual
);
   // Quiet lines at time zero
   initial begin
      sync_det = 1'b0;
      rxb = '0;
      crc_res = '0;
      rqual = '0;
   end
   // Sync, bytes two cycles apart, then the verdict if checking is on
   task automatic send(input logic [7:0] q[$], input logic ok,
      input logic cen, input rpf_pkg::rpf_qual_t qv);
      @(negedge clk_sys);
      rqual = qv;
      sync_det = 1'b1;
      @(negedge clk_sys);
      sync_det = 1'b0;
      foreach (q[i]) begin
         @(negedge clk_sys);
         rxb = {1'b1, q[i]};
         @(negedge clk_sys);
         rxb = {1'b0, ~q[i]}; // Stale byte never lingers
      end
      if (cen) begin
         crc_res = {1'b1, ok};
         @(negedge clk_sys);
         crc_res = {1'b0, ~ok};
      end
      // Room for the two trailer bytes
      repeat (6) @(negedge clk_sys);
   endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the receive packet filter top.
// Assumes rpf_src as stream source; the bench plays the host.
`timescale 1ns/10ps
module testbench;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   rpf_pkg::rpf_reg_req_t reg_req = '0;
   logic fifo_rd = 1'b0;
   logic [6:0] tx_count = '0;
   logic rd_d = 1'b0;
   logic sync_det, rx_thr, tx_thr, crc_enable, fifo_empty, rx_ovf;
   rpf_pkg::rpf_rxb_t rxb;
   rpf_pkg::rpf_crc_t crc_res;
   rpf_pkg::rpf_qual_t rqual;
   logic [7:0] reg_rdata, fifo_rdata, ad;
   logic [6:0] rx_count;
   logic [15:0] sync_word, s;
   logic [1:0] pkt_format;
   logic acc;
   logic [7:0] exp_q[$];
   logic [7:0] adl[4] = '{8'h5A, 8'h00, 8'hFF, 8'h33};
   int n_errors = 0;
   int n_compared = 0;
   int seed = 71;
   int cyc = 0;
   int n, f, i;

   // Free-running 25 MHz clock
   always #20 clk_sys = ~clk_sys;

   rpf_top u_rpf_top (.clk_sys, .rst_n, .ce(1'b1), .reg_req, .reg_rdata,
      .sync_det, .rxb, .crc_res, .rqual, .rx_abort(1'b0), .fifo_rd,
      .fifo_flush(1'b0), .fifo_rdata, .fifo_empty, .rx_count, .rx_ovf,
      .tx_count, .rx_thr, .tx_thr, .sync_word, .crc_enable, .pkt_format);
   rpf_src u_rpf_src (.clk_sys, .sync_det, .rxb, .crc_res, .rqual);

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_req = {1'b1, a, d};
      @(negedge clk_sys);
      reg_req.wr = 1'b0;
   endtask

   // Read data is registered: look one cycle after the address
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(negedge clk_sys);
      reg_req = {1'b0, a, 8'h00};
      @(negedge clk_sys);
      chk(reg_rdata, e);
   endtask

   // Builds a packet and notes its bytes when it should be kept
   task automatic pkt(input logic [7:0] a, input int np, input logic ok,
      input logic keep, input logic trl, input logic cen, input logic fx);
      logic [7:0] q[$];
      rpf_pkg::rpf_qual_t qv;
      qv = 15'($random(seed));
      if (!fx) q.push_back(8'(np + 1));
      q.push_back(a);
      repeat (np) q.push_back(8'($random(seed)));
      if (keep) begin
         foreach (q[k]) exp_q.push_back(q[k]);
         if (trl) exp_q.push_back(qv.rssi);
         if (trl) exp_q.push_back({ok & cen, qv.lqi});
      end
      u_rpf_src.send(q, ok, cen, qv);
   endtask

   // Pops one byte at a time until empty, then nothing may be owed
   task automatic drain();
      int k;
      for (k = 0; k < 80 && fifo_empty !== 1'b1; k++) begin
         @(negedge clk_sys);
         fifo_rd = 1'b1;
         @(negedge clk_sys);
         fifo_rd = 1'b0;
      end
      @(negedge clk_sys);
      chk(16'(exp_q.size()), 16'h0000);
      chk(rx_ovf, 1'b0);
   endtask

   // A pop shows its byte one edge later
   always @(posedge clk_sys) begin
      rd_d <= fifo_rd & ~fifo_empty;
   end
   // Oldest note against each popped byte
   always @(negedge clk_sys) begin
      if (rd_d && exp_q.size() > 0) chk(fifo_rdata, exp_q.pop_front());
      else if (rd_d) chk(fifo_rdata, 16'hxxxx);
   end

   // Hang guard, well above the under one thousand cycles needed
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         $display("[ERR] %0t timeout", $time);
         summarize();
      end
   end

   initial begin
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (3) @(negedge clk_sys);
      rd(6'h04, 8'hD3);
      rd(6'h05, 8'h91);
      rd(6'h06, 8'hFF);
      rd(6'h07, 8'h04);
      rd(6'h09, 8'h00);
      rd(6'h08, 8'h45);
      rd(6'h3F, 8'h00);
      rd(6'h03, 8'h07);
      chk(crc_enable, 1'b1);
      chk(pkt_format, 2'b00);
      chk(sync_word, 16'hD391);
      s = 16'($random(seed));
      wr(6'h04, s[15:8]);
      wr(6'h05, s[7:0]);
      chk(sync_word, s);
      wr(6'h07, 8'hFF);
      rd(6'h07, 8'hEF);
      wr(6'h08, 8'hFF);
      rd(6'h08, 8'h77);
      chk(pkt_format, 2'b11);
      wr(6'h08, 8'h41);
      chk(crc_enable, 1'b0);
      wr(6'h08, 8'h45);
      $display("test registers done");
      wr(6'h09, 8'h5A);
      for (f = 0; f < 4; f++) begin
         wr(6'h07, {6'h01, 2'(f)});
         for (i = 0; i < 4; i++) begin
            ad = adl[i];
            acc = f == 0 || ad == 8'h5A || (f > 1 && ad == 8'h00) ||
               (f == 3 && ad == 8'hFF);
            pkt(ad, 2, 1'b1, acc, 1'b1, 1'b1, 1'b0);
         end
         chk(rx_count, 7'(exp_q.size()));
         if (f == 0) begin
            wr(6'h03, 8'h05);
            chk(rx_thr, 1'b1);
            wr(6'h03, 8'h06);
            chk(rx_thr, 1'b0);
         end
         drain();
      end
      $display("test filters done");
      for (n = 0; n < 16; n++) begin
         wr(6'h03, 8'(n));
         tx_count = 7'(61 - 4 * n);
         #1 chk(tx_thr, 1'b1);
         tx_count = 7'(60 - 4 * n);
         #1 chk(tx_thr, 1'b0);
      end
      $display("test thresholds done");
      wr(6'h07, 8'h04);
      wr(6'h06, 8'h03);
      pkt(8'h21, 3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      pkt(8'h22, 2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
      wr(6'h08, 8'h44);
      pkt(8'h23, 2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
      wr(6'h08, 8'h41);
      pkt(8'h24, 2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      drain();
      wr(6'h08, 8'h45);
      wr(6'h07, 8'h00);
      pkt(8'h25, 2, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
      drain();
      wr(6'h07, 8'h0C);
      pkt(8'h26, 2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      chk(rx_count, 7'h00);
      pkt(8'h27, 2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
      drain();
      $display("test lengths and flush done");
      summarize();
   end
endmodule
